// *** design/rss_supervisor.sv ***
/*
 * Run, sleep and restart supervisor of a motor drive: power-up terminal run
 * protection, low-frequency action, sleep with delayed wake-up and automatic
 * restart after power loss.
 * Assumes settings are stable static levels from the parameter store, the
 * run terminal is asynchronous and frequencies come from logic on sys_clk.
 * Power-on is the release of rst_n; init_done pulses or holds high once
 * initialisation is complete.
 */
`timescale 1ns/100ps
`include "rss_params.svh"

// Functional notes
// R1 - Sample run terminal at power-up in terminal mode
// R2 - Protect zero: hold until terminal released, reasserted
// R3 - Protect one: auto-start after init if active
// R4 - Low-frequency ones digit: limit, stop, sleep
// R5 - Tens digit picks coast or decelerate stop
// R6 - Resume after set above limit for delay
// R7 - Sleep on low run frequency, delayed wake
// R8 - Restart enable chooses auto-run at power-on
// R9 - Count restart wait from power-on, 1.0s; the code starts counting when init_done is seen, not at rst_n release
// R10 - Protect, restart enable, wake delay reset zero
// R11 - Restart wait 0-3600.0s, only when enabled
// R12 - Sleep entry delay elapses before sleeping
// R13 - Delays count 0.1s ticks, restart on interruption
module rss_supervisor #(
   parameter int FREQ_W      = 16,
   parameter int TICK_CYCLES = `RSS_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   // Run command and power-up status
   input  wire logic                 run_cmd_from_terminal,
   input  wire logic                 run_terminal_in,
   input  wire logic                 init_done,
   // Frequencies
   input  wire logic [FREQ_W-1:0]    set_freq,
   input  wire logic [FREQ_W-1:0]    running_freq,
   input  wire logic [FREQ_W-1:0]    freq_lower_limit,
   // Settings, delays in 0.1 s units
   input  wire logic                 powerup_terminal_run_protect,
   input  wire logic [7:0]           low_freq_action_select,
   input  wire logic [15:0]          wake_from_sleep_delay,
   input  wire logic                 restart_after_power_loss_enable,
   input  wire logic [15:0]          restart_wait_time,
   input  wire logic [15:0]          sleep_entry_delay,
   // Requests to the drive core
   output logic                      run_req,
   output rss_pkg::rss_stop_mode_t   stop_mode,
   output logic                      sleep_req,
   output logic                      run_at_lower_limit,
   output logic                      run_protect_active
);
   import rss_pkg::*;

   // Refuse widths and tick lengths the counters cannot serve
   if (FREQ_W < 1 || TICK_CYCLES < 1) begin : g_bad_param
      $error("rss_supervisor: bad parameter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Terminal synchroniser and 0.1 s tick
   localparam int TW = $clog2(TICK_CYCLES + 1);

   logic          term_s1_q;
   logic          term_s2_q;
   logic          term_prev_q;
   logic [TW-1:0] tick_cnt_q;
   logic [TW-1:0] tick_cnt_d;
   logic          tick;

   always_comb begin
      tick       = (tick_cnt_q == TW'(TICK_CYCLES - 1));
      tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);  // R13
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         term_s1_q   <= 1'b0;
         term_s2_q   <= 1'b0;
         term_prev_q <= 1'b0;
         tick_cnt_q  <= '0;
      end else begin
         term_s1_q   <= run_terminal_in;
         term_s2_q   <= term_s1_q;
         term_prev_q <= term_s2_q;
         tick_cnt_q  <= tick_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode of conditions
   rss_lf_act_t    lf_act;
   rss_stop_mode_t lf_stop_mode;
   logic           limit_on;
   logic           set_low;
   logic           set_high;
   logic           run_low;
   logic           term_rise;
   logic           term_fall;
   logic [15:0]    restart_wait_lim;

   always_comb begin
      lf_act       = rss_lf_act_t'(low_freq_action_select[`RSS_LF_ACT_LSB +: 2]);  // R4
      lf_stop_mode = rss_stop_mode_t'(low_freq_action_select[`RSS_LF_STOPMODE_LSB]);  // R5
      limit_on     = (freq_lower_limit != '0);
      set_low      = limit_on && (set_freq < freq_lower_limit);
      set_high     = set_freq > freq_lower_limit;
      run_low      = limit_on && (running_freq < freq_lower_limit);
      term_rise    = term_s2_q && !term_prev_q;
      term_fall    = !term_s2_q && term_prev_q;
      restart_wait_lim = (restart_wait_time > `RSS_DELAY_MAX) ? `RSS_DELAY_MAX
                                                             : restart_wait_time;  // R11
   end

   ////////////////////////////////////////////////////////////////////////////
   // Supervisor state machine
   rss_state_t     state_q;
   rss_state_t     state_d;
   logic [15:0]    dly_q;
   logic [15:0]    dly_d;
   logic           pu_term_q;
   logic           pu_term_d;
   logic           run_d;
   logic           sleep_d;
   logic           limit_run_d;
   logic           protect_d;
   rss_stop_mode_t stop_mode_d;

   always_comb begin
      state_d     = state_q;
      dly_d       = dly_q;
      pu_term_d   = pu_term_q;
      stop_mode_d = stop_mode;
      unique case (state_q)
         RSS_ST_POWERUP: begin
            pu_term_d = run_cmd_from_terminal && term_s2_q;  // R1
            dly_d     = '0;
            if (init_done) begin
               if (restart_after_power_loss_enable) begin
                  state_d = RSS_ST_RESTART_WAIT;  // R8
               end else if (pu_term_d && !powerup_terminal_run_protect) begin
                  state_d = RSS_ST_PROTECT;  // R2
               end else if (pu_term_d) begin
                  state_d = RSS_ST_RUN;  // R3
               end else begin
                  state_d = RSS_ST_IDLE;
               end
            end
         end
         RSS_ST_RESTART_WAIT: begin
            if (dly_q >= restart_wait_lim) begin
               state_d = RSS_ST_RUN;  // R9
               dly_d   = '0;
            end else if (tick) begin
               dly_d = dly_q + 16'd1;
            end
         end
         RSS_ST_PROTECT: begin
            if (term_fall) begin
               state_d = RSS_ST_IDLE;  // R2
            end
         end
         RSS_ST_IDLE: begin
            if (run_cmd_from_terminal && term_rise) begin
               state_d = RSS_ST_RUN;
               dly_d   = '0;
            end
         end
         RSS_ST_RUN: begin
            if (run_cmd_from_terminal && !term_s2_q) begin
               state_d = RSS_ST_IDLE;
            end else if (set_low && lf_act == RSS_LF_STOP) begin
               state_d     = RSS_ST_LF_STOP;  // R4
               stop_mode_d = lf_stop_mode;  // R5
               dly_d       = '0;
            end else if (run_low && lf_act == RSS_LF_SLEEP) begin
               if (dly_q >= sleep_entry_delay) begin
                  state_d     = RSS_ST_SLEEP;  // R7 R12
                  stop_mode_d = lf_stop_mode;  // R5
                  dly_d       = '0;
               end else if (tick) begin
                  dly_d = dly_q + 16'd1;
               end
            end else begin
               dly_d = '0;  // R13
            end
         end
         RSS_ST_LF_STOP,
         RSS_ST_SLEEP: begin
            if (run_cmd_from_terminal && !term_s2_q) begin
               state_d = RSS_ST_IDLE;
               dly_d   = '0;
            end else if (!set_high) begin
               dly_d = '0;  // R13
            end else if (dly_q >= ((state_q == RSS_ST_SLEEP) ? wake_from_sleep_delay : 16'd0)) begin
               state_d = RSS_ST_RUN;  // R6 R7
               dly_d   = '0;
            end else if (tick) begin
               dly_d = dly_q + 16'd1;
            end
         end
      endcase
      run_d       = (state_d == RSS_ST_RUN);
      sleep_d     = (state_d == RSS_ST_SLEEP);
      protect_d   = (state_d == RSS_ST_PROTECT);
      limit_run_d = run_d && set_low && (lf_act == RSS_LF_RUN_AT_LIMIT);  // R4
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q            <= RSS_ST_POWERUP;
         dly_q              <= '0;
         pu_term_q          <= 1'b0;
         run_req            <= 1'b0;
         sleep_req          <= 1'b0;
         run_at_lower_limit <= 1'b0;
         run_protect_active <= 1'b0;
         stop_mode          <= RSS_STOP_COAST;
      end else begin
         state_q            <= state_d;
         dly_q              <= dly_d;
         pu_term_q          <= pu_term_d;
         run_req            <= run_d;
         sleep_req          <= sleep_d;
         run_at_lower_limit <= limit_run_d;
         run_protect_active <= protect_d;
         stop_mode          <= stop_mode_d;
      end
   end
endmodule

// *** design/rss_params.svh ***
/*
 * Constants for the run, sleep and restart supervisor: reset values of the
 * settings, field positions and the tick timing.
 * Assumes a 200 MHz system clock and times counted in 0.1 s steps.
 */
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH

`define RSS_CLK_HZ            200000000
`define RSS_TICK_MS           100
`define RSS_TICK_CYCLES       (`RSS_CLK_HZ / 1000 * `RSS_TICK_MS)
`define RSS_DELAY_MAX         16'd36000
`define RSS_PROTECT_RST       1'b0  // R10
`define RSS_RESTART_EN_RST    1'b0  // R10
`define RSS_LF_SEL_RST        8'h00  // R4
`define RSS_WAKE_DELAY_RST    16'd0  // R10
`define RSS_SLEEP_DELAY_RST   16'd0  // R12
`define RSS_RESTART_WAIT_RST  16'd10  // R9
`define RSS_LF_ACT_LSB        0
`define RSS_LF_STOPMODE_LSB   4

`endif

// *** design/rss_pkg.sv ***
/*
 * Types shared by the run, sleep and restart supervisor.
 * Assumes nothing beyond the params header.
 */
package rss_pkg;
   typedef enum logic [1:0] {
      RSS_LF_RUN_AT_LIMIT = 2'h0,
      RSS_LF_STOP         = 2'h1,
      RSS_LF_SLEEP        = 2'h2
   } rss_lf_act_t;

   typedef enum logic {
      RSS_STOP_COAST = 1'b0,
      RSS_STOP_DECEL = 1'b1
   } rss_stop_mode_t;

   typedef enum {
      RSS_ST_POWERUP,
      RSS_ST_RESTART_WAIT,
      RSS_ST_PROTECT,
      RSS_ST_IDLE,
      RSS_ST_RUN,
      RSS_ST_LF_STOP,
      RSS_ST_SLEEP
   } rss_state_t;
endpackage

// *** testbench/rss_far_side.sv ***
/* Far-side model: run terminal, setpoint source and motor speed feedback.
   Assumes the bench commands levels; all lines change on the falling edge. */
`timescale 1ns/100ps
module rss_far_side (
   // Clock and commands
   input  wire logic        sys_clk, term_cmd, run_req,
   input  wire logic [15:0] set_cmd,
   // Pins toward the supervisor
   output logic             run_terminal_in,
   output logic [15:0]      set_freq, running_freq
);
   // Motor speed follows the setpoint only while the drive runs
   always @(negedge sys_clk) begin
      run_terminal_in <= term_cmd;
      set_freq        <= set_cmd;
      running_freq    <= run_req ? set_cmd : 16'h0000;
   end
endmodule

// *** testbench/rss_sup_asserts.sv ***
/* Checker for the supervisor outputs.
   Assumes settings only change while reset is held or the drive runs normally. */
`timescale 1ns/100ps
module rss_sup_asserts #(parameter int FREQ_W = 16, parameter int TICK_CYCLES = 10) (
   // Clock, reset and inputs
   input wire logic                    sys_clk, rst_n, run_cmd_from_terminal, run_terminal_in,
   input wire logic [FREQ_W-1:0]       set_freq, freq_lower_limit,
   input wire logic [7:0]              low_freq_action_select,
   input wire logic                    restart_after_power_loss_enable,
   input wire logic [15:0]             restart_wait_time,
   // Outputs
   input wire logic                    run_req, sleep_req, run_at_lower_limit, run_protect_active,
   input wire rss_pkg::rss_stop_mode_t stop_mode
);
   import rss_pkg::*;
   logic [31:0] cyc_q, cyc_d;
   // Cycles since power-on, saturating
   always_comb cyc_d = (cyc_q == 32'hFFFFFFFF) ? cyc_q : cyc_q + 32'h1;
   always_ff @(posedge sys_clk or negedge rst_n) if (!rst_n) cyc_q <= '0; else cyc_q <= cyc_d;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> !run_req && !sleep_req) else $error("output active at power-on");
   a_protect_stopped: assert property (run_protect_active |-> !run_req) else $error("run while protected");
   a_sleep_stopped: assert property (sleep_req |-> !run_req && !run_at_lower_limit) else $error("run while asleep");
   a_limit_cause: assert property (run_at_lower_limit |-> run_req && freq_lower_limit != 0
      && $past(low_freq_action_select[1:0] == 2'h0)) else $error("limit run without cause");
   a_sleep_entry: assert property ($rose(sleep_req) |-> $past(low_freq_action_select[1:0] == 2'h2)
      && stop_mode == low_freq_action_select[4]) else $error("bad sleep entry");
   a_sleep_hold: assert property (sleep_req && run_terminal_in && set_freq <= freq_lower_limit
      && $past(set_freq <= freq_lower_limit) |=> sleep_req) else $error("woke without setpoint");
   a_restart_wait: assert property ($rose(run_req) && restart_after_power_loss_enable && !run_cmd_from_terminal
      |-> cyc_q + TICK_CYCLES >= restart_wait_time * TICK_CYCLES) else $error("restart too early");
   a_source_idle: assert property (!run_cmd_from_terminal && !restart_after_power_loss_enable |-> !run_req)
      else $error("run without source");
   cover property ($rose(sleep_req));
   cover property ($rose(run_protect_active));
   cover property ($rose(run_at_lower_limit));
endmodule
bind rss_supervisor rss_sup_asserts #(.FREQ_W(FREQ_W), .TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk(sys_clk),
   .rst_n(rst_n), .run_cmd_from_terminal(run_cmd_from_terminal), .run_terminal_in(run_terminal_in),
   .set_freq(set_freq), .freq_lower_limit(freq_lower_limit), .low_freq_action_select(low_freq_action_select),
   .restart_after_power_loss_enable(restart_after_power_loss_enable), .restart_wait_time(restart_wait_time),
   .run_req(run_req), .sleep_req(sleep_req), .run_at_lower_limit(run_at_lower_limit),
   .run_protect_active(run_protect_active), .stop_mode(stop_mode));

// *** testbench/testbench.sv ***
/* Self-checking bench for the supervisor with a 10-cycle tick.
   Assumes the far-side model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`include "rss_params.svh"
module testbench;
   import rss_pkg::*;
   logic           sys_clk = 1'b0, rst_n = 1'b0, src = 1'b1, term = 1'b0, init_done = 1'b0, prot = 1'b0, rse = 1'b0;
   logic [15:0]    set_cmd = 16'h00C8;
   logic [15:0]    rwt = 16'h0003, sed = 16'h0002;
   logic [7:0]     lfs = 8'h00;
   logic           run_terminal_in, run_req, sleep_req, run_at_lower_limit, run_protect_active;
   logic [15:0]    set_freq, running_freq;
   rss_stop_mode_t stop_mode;
   int             mismatches = 0, n_checks = 0, cyc = 0;
   initial forever #2.5 sys_clk = ~sys_clk;
   rss_far_side far (.sys_clk(sys_clk), .term_cmd(term), .run_req(run_req), .set_cmd(set_cmd),
      .run_terminal_in(run_terminal_in), .set_freq(set_freq), .running_freq(running_freq));
   rss_supervisor #(.FREQ_W(16), .TICK_CYCLES(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .run_cmd_from_terminal(src), .run_terminal_in(run_terminal_in), .init_done(init_done),
      .set_freq(set_freq), .running_freq(running_freq), .freq_lower_limit(16'h0064),
      .powerup_terminal_run_protect(prot), .low_freq_action_select(lfs), .wake_from_sleep_delay(16'h0003),
      .restart_after_power_loss_enable(rse), .restart_wait_time(rwt), .sleep_entry_delay(sed),
      .run_req(run_req), .stop_mode(stop_mode), .sleep_req(sleep_req),
      .run_at_lower_limit(run_at_lower_limit), .run_protect_active(run_protect_active));
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(string what, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cycles(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Power-on with the given source, terminal, protection and restart settings
   task automatic power_up(logic s, logic t, logic p, logic r, logic [15:0] w = 16'h0003);
      rst_n = 1'b0; init_done = 1'b0; src = s; term = t; prot = p; rse = r; lfs = `RSS_LF_SEL_RST; set_cmd = 16'h00C8;
      rwt = w;
      cycles(2);
      rst_n = 1'b1;
      cycles(5);
      init_done = 1'b1;
      cycles(2);
   endtask
   task automatic test_protect();
      power_up(1'b1, 1'b1, 1'b0, 1'b0);
      cycles(20);
      chk("protect_active", 1'b1, run_protect_active);
      chk("run_req", 1'b0, run_req);
      term = 1'b0;
      cycles(10);
      term = 1'b1;
      cycles(10);
      chk("run_req", 1'b1, run_req);
      $display("test_protect done");
   endtask
   task automatic test_low_freq();
      power_up(1'b1, 1'b1, 1'b1, 1'b0);
      cycles(20);
      chk("run_req", 1'b1, run_req);
      set_cmd = 16'h0032;
      cycles(10);
      chk("run_at_lower_limit", 1'b1, run_at_lower_limit);
      set_cmd = 16'h00C8;
      cycles(5);
      lfs = 8'h11;
      set_cmd = 16'h0032;
      cycles(10);
      chk("run_req", 1'b0, run_req);
      chk("stop_mode", 1'b1, stop_mode);
      set_cmd = 16'h00C8;
      cycles(10);
      chk("run_req", 1'b1, run_req);
      lfs = 8'h02;
      cycles(5);
      set_cmd = 16'h0032;
      cycles(5);
      chk("sleep_req", 1'b0, sleep_req);
      cycles(35);
      chk("sleep_req", 1'b1, sleep_req);
      chk("stop_mode", 1'b0, stop_mode);
      set_cmd = 16'h00C8;
      cycles(15);
      set_cmd = 16'h0032;
      cycles(5);
      chk("sleep_req", 1'b1, sleep_req);
      set_cmd = 16'h00C8;
      cycles(45);
      chk("run_req", 1'b1, run_req);
      $display("test_low_freq done");
   endtask
   task automatic test_restart();
      power_up(1'b0, 1'b0, 1'b0, 1'b1);
      chk("run_req", 1'b0, run_req);
      cycles(40);
      chk("run_req", 1'b1, run_req);
      power_up(1'b0, 1'b0, 1'b0, 1'b0);
      cycles(60);
      chk("run_req", 1'b0, run_req);
      $display("test_restart done");
   endtask
   // Protect, restart and low-frequency settings at reset values, restart enable set for the second power-on: protection on, restart waits ten ticks
   task automatic test_defaults();
      power_up(1'b1, 1'b1, `RSS_PROTECT_RST, `RSS_RESTART_EN_RST, `RSS_RESTART_WAIT_RST);
      cycles(20);
      chk("protect_active", 1'b1, run_protect_active);
      chk("run_req", 1'b0, run_req);
      power_up(1'b0, 1'b0, 1'b0, 1'b1, `RSS_RESTART_WAIT_RST);
      cycles(85);
      chk("run_req", 1'b0, run_req);
      cycles(20);
      chk("run_req", 1'b1, run_req);
      $display("test_defaults done");
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      test_protect();
      test_low_freq();
      test_restart();
      test_defaults();
      test_done();
   end
endmodule
